// ===== logic/drive_control_status_limits.sv
// Control word decoder, drive state machine, status word and position limits.
// Overview of operation
// - Hardware limits always; software only absolute PP/CSP.
// - Negative limit subindex 1, positive subindex 2.
// - Config bits choose raw, plus or minus offset.
// - Limit settings change only in pre-operational.
// - Incremental encoder: software limits after homing.
// - Control word bits decoded per definition.
// - 0006h shutdown, 0007h switch on, 000Fh enable.
// - Disable voltage, quick stop, fault reset edge.
// - In ready state 000Fh acts as switch on.
// - Halt, setpoint, immediate, relative, homing start bits.
// - Status word bits reported per definition.
// - Bit11 set while any limit is active.
// - State encoded in status bits 6,5,3..0.
// - Mode-specific status bits per operating mode.
// - Halt stops with profile deceleration in PP, PV, PT and homing modes.
`timescale 1ns/1ns
module drive_control_status_limits
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdWrite,
  input wire logic [15:0] cmdData,
  input wire logic [2:0] opMode,
  input wire logic preOperational,
  input wire logic limitWrite,
  input wire logic limitSub,
  input wire logic [31:0] limitData,
  input wire logic configWrite,
  input wire logic [7:0] configData,
  input wire logic [31:0] homeOffset,
  input wire logic [31:0] targetPosition,
  input wire logic [31:0] actualPosition,
  input wire logic incrementalEncoder,
  input wire logic homingDone,
  input wire logic homingError,
  input wire logic posErrorLarge,
  input wire logic velocityZero,
  input wire logic followingValid,
  input wire logic abnormalStop,
  input wire logic targetReached,
  input wire logic faultEvent,
  input wire logic faultReactionDone,
  input wire logic hwLimitPosPin,
  input wire logic hwLimitNegPin,
  output logic [15:0] drive_command_word,
  output logic [15:0] drive_state_word,
  output logic powerEnable,
  output logic torqueEnable,
  output logic haltDecel,
  output logic quickStopDecel,
  output logic newSetpoint,
  output logic immediateTrigger,
  output logic relativeMove,
  output logic homingStart,
  output logic blockPositive,
  output logic blockNegative
);
  typedef struct packed {
    dcsl_pkg::dcsl_state_type state;
    logic [15:0] command;
    logic [15:0] status;
    logic [31:0] limitNeg;
    logic [31:0] limitPos;
    logic [7:0] offsetConfig;
    logic prevFaultReset;
    logic powerEnable;
    logic torqueEnable;
    logic haltDecel;
    logic quickStopDecel;
    logic newSetpoint;
    logic immediateTrigger;
    logic relativeMove;
    logic homingStart;
    logic blockPositive;
    logic blockNegative;
  } dcsl_regs_type;

  dcsl_regs_type r;
  dcsl_regs_type next_r;
  logic hwPos;
  logic hwNeg;
  logic [31:0] effNeg;
  logic [31:0] effPos;

  dcsl_pin_sync syncPos
  (
    .clk(clk),
    .rstn(rstn),
    .pin(hwLimitPosPin),
    .level(hwPos)
  );

  dcsl_pin_sync syncNeg
  (
    .clk(clk),
    .rstn(rstn),
    .pin(hwLimitNegPin),
    .level(hwNeg)
  );

  dcsl_limit_calc calcNeg
  (
    .rawLimit(r.limitNeg),
    .homeOffset(homeOffset),
    .offsetConfig(r.offsetConfig),
    .effLimit(effNeg)
  );

  dcsl_limit_calc calcPos
  (
    .rawLimit(r.limitPos),
    .homeOffset(homeOffset),
    .offsetConfig(r.offsetConfig),
    .effLimit(effPos)
  );

  always_comb
  begin
    logic [15:0] cw;
    logic [3:0] low;
    logic frEdge;
    logic swActive;
    logic swPos;
    logic swNeg;
    logic modePos;
    dcsl_pkg::dcsl_state_type st;
    logic [15:0] sw;
    cw = r.command;
    low = 4'h0;
    frEdge = 1'b0;
    swActive = 1'b0;
    swPos = 1'b0;
    swNeg = 1'b0;
    modePos = 1'b0;
    st = r.state;
    sw = 16'h0000;
    next_r = r;
    if (cmdWrite)
    begin
      cw = cmdData;
    end
    next_r.command = cw;
    low = cw[3:0] & dcsl_pkg::CMD_MASK;
    frEdge = cw[dcsl_pkg::CW_FAULT_RESET] & ~r.prevFaultReset;
    next_r.prevFaultReset = cw[dcsl_pkg::CW_FAULT_RESET];
    if (limitWrite && preOperational)
    begin
      if (limitSub)
      begin
        next_r.limitPos = limitData;
      end
      else
      begin
        next_r.limitNeg = limitData;
      end
    end
    if (configWrite && preOperational)
    begin
      next_r.offsetConfig = configData;
    end
    // Fault events reach every state but the two fault states, so a fault beats any command this cycle.
    case (r.state)
      dcsl_pkg::DCSL_NOT_READY:
      begin
        st = dcsl_pkg::DCSL_ON_DISABLED;
      end
      dcsl_pkg::DCSL_ON_DISABLED:
      begin
        if (cw[dcsl_pkg::CW_ENABLE_VOLTAGE] && cw[dcsl_pkg::CW_QUICK_STOP_N]
            && !cw[dcsl_pkg::CW_FAULT_RESET] && low[2:1] == 2'b11
            && !cw[dcsl_pkg::CW_SWITCH_ON])
        begin
          st = dcsl_pkg::DCSL_READY;
        end
      end
      dcsl_pkg::DCSL_READY:
      begin
        if (!cw[dcsl_pkg::CW_ENABLE_VOLTAGE] || !cw[dcsl_pkg::CW_QUICK_STOP_N])
        begin
          st = dcsl_pkg::DCSL_ON_DISABLED;
        end
        else if (low == dcsl_pkg::CMD_SWITCH_ON || low == dcsl_pkg::CMD_ENABLE)
        begin
          st = dcsl_pkg::DCSL_SWITCHED_ON;
        end
      end
      dcsl_pkg::DCSL_SWITCHED_ON:
      begin
        if (!cw[dcsl_pkg::CW_ENABLE_VOLTAGE] || !cw[dcsl_pkg::CW_QUICK_STOP_N])
        begin
          st = dcsl_pkg::DCSL_ON_DISABLED;
        end
        else if (low == dcsl_pkg::CMD_SHUTDOWN)
        begin
          st = dcsl_pkg::DCSL_READY;
        end
        else if (low == dcsl_pkg::CMD_ENABLE)
        begin
          st = dcsl_pkg::DCSL_OP_ENABLED;
        end
      end
      dcsl_pkg::DCSL_OP_ENABLED:
      begin
        if (!cw[dcsl_pkg::CW_ENABLE_VOLTAGE])
        begin
          st = dcsl_pkg::DCSL_ON_DISABLED;
        end
        else if (!cw[dcsl_pkg::CW_QUICK_STOP_N])
        begin
          st = dcsl_pkg::DCSL_QUICK_STOP;
        end
        else if (low == dcsl_pkg::CMD_SHUTDOWN)
        begin
          st = dcsl_pkg::DCSL_READY;
        end
        else if (low == dcsl_pkg::CMD_SWITCH_ON)
        begin
          st = dcsl_pkg::DCSL_SWITCHED_ON;
        end
      end
      dcsl_pkg::DCSL_QUICK_STOP:
      begin
        if (!cw[dcsl_pkg::CW_ENABLE_VOLTAGE])
        begin
          st = dcsl_pkg::DCSL_ON_DISABLED;
        end
        else if (low == dcsl_pkg::CMD_ENABLE)
        begin
          st = dcsl_pkg::DCSL_OP_ENABLED;
        end
        else if (low == dcsl_pkg::CMD_SWITCH_ON)
        begin
          st = dcsl_pkg::DCSL_SWITCHED_ON;
        end
      end
      dcsl_pkg::DCSL_FAULT_REACT:
      begin
        if (faultReactionDone)
        begin
          st = dcsl_pkg::DCSL_FAULT;
        end
      end
      dcsl_pkg::DCSL_FAULT:
      begin
        if (frEdge && !faultEvent)
        begin
          st = dcsl_pkg::DCSL_ON_DISABLED;
        end
      end
      default:
      begin
        st = r.state;
      end
    endcase
    if (faultEvent && r.state != dcsl_pkg::DCSL_FAULT
        && r.state != dcsl_pkg::DCSL_FAULT_REACT)
    begin
      st = dcsl_pkg::DCSL_FAULT_REACT;
    end
    next_r.state = st;

    next_r.haltDecel = cw[dcsl_pkg::CW_HALT]
      && (opMode == dcsl_pkg::DCSL_MODE_PP || opMode == dcsl_pkg::DCSL_MODE_PV
      || opMode == dcsl_pkg::DCSL_MODE_PT || opMode == dcsl_pkg::DCSL_MODE_HM);
    next_r.torqueEnable = st == dcsl_pkg::DCSL_OP_ENABLED
      || st == dcsl_pkg::DCSL_QUICK_STOP || st == dcsl_pkg::DCSL_FAULT_REACT;
    next_r.powerEnable = st == dcsl_pkg::DCSL_SWITCHED_ON || next_r.torqueEnable;
    next_r.quickStopDecel = st == dcsl_pkg::DCSL_QUICK_STOP;
    next_r.newSetpoint = opMode == dcsl_pkg::DCSL_MODE_PP
      && cw[dcsl_pkg::CW_NEW_SETPOINT];
    next_r.immediateTrigger = opMode == dcsl_pkg::DCSL_MODE_PP
      && cw[dcsl_pkg::CW_IMMEDIATE];
    next_r.relativeMove = opMode == dcsl_pkg::DCSL_MODE_PP
      && cw[dcsl_pkg::CW_RELATIVE];
    next_r.homingStart = opMode == dcsl_pkg::DCSL_MODE_HM
      && cw[dcsl_pkg::CW_NEW_SETPOINT];

    modePos = opMode == dcsl_pkg::DCSL_MODE_CSP
      || (opMode == dcsl_pkg::DCSL_MODE_PP && !cw[dcsl_pkg::CW_RELATIVE]);
    swActive = modePos && (!incrementalEncoder || homingDone);
    // Signed compare; target beyond the limit or actual at or beyond it trips it.
    swPos = swActive && ($signed(targetPosition) > $signed(effPos)
      || $signed(actualPosition) >= $signed(effPos));
    swNeg = swActive && ($signed(targetPosition) < $signed(effNeg)
      || $signed(actualPosition) <= $signed(effNeg));
    next_r.blockPositive = hwPos || swPos;
    next_r.blockNegative = hwNeg || swNeg;

    case (st)
      dcsl_pkg::DCSL_ON_DISABLED: sw[6:0] = 7'b1000000;
      dcsl_pkg::DCSL_READY: sw[6:0] = 7'b0110001;
      dcsl_pkg::DCSL_SWITCHED_ON: sw[6:0] = 7'b0110011;
      dcsl_pkg::DCSL_OP_ENABLED: sw[6:0] = 7'b0110111;
      dcsl_pkg::DCSL_QUICK_STOP: sw[6:0] = 7'b0010111;
      dcsl_pkg::DCSL_FAULT_REACT: sw[6:0] = 7'b0001111;
      dcsl_pkg::DCSL_FAULT: sw[6:0] = 7'b0001000;
      default: sw[6:0] = 7'b0000000;
    endcase
    // Status bits
    // Supply counts as present once out of reset; the enable sequence needs it.
    sw[dcsl_pkg::SW_VOLTAGE] = st != dcsl_pkg::DCSL_NOT_READY;
    sw[dcsl_pkg::SW_REMOTE] = 1'b1;
    sw[dcsl_pkg::SW_TARGET] = targetReached;
    sw[dcsl_pkg::SW_LIMIT] = next_r.blockPositive || next_r.blockNegative;
    case (opMode)
      dcsl_pkg::DCSL_MODE_PP:
      begin
        sw[dcsl_pkg::SW_MODE_HIGH] = posErrorLarge;
        sw[dcsl_pkg::SW_MODE_LOW] = abnormalStop;
      end
      dcsl_pkg::DCSL_MODE_PV:
      begin
        sw[dcsl_pkg::SW_MODE_MID] = velocityZero;
      end
      dcsl_pkg::DCSL_MODE_HM:
      begin
        sw[dcsl_pkg::SW_MODE_HIGH] = homingError;
        sw[dcsl_pkg::SW_MODE_MID] = homingDone;
        sw[dcsl_pkg::SW_MODE_LOW] = abnormalStop;
      end
      dcsl_pkg::DCSL_MODE_CSP:
      begin
        sw[dcsl_pkg::SW_MODE_MID] = followingValid;
        sw[dcsl_pkg::SW_MODE_LOW] = abnormalStop;
      end
      dcsl_pkg::DCSL_MODE_CSV, dcsl_pkg::DCSL_MODE_CST:
      begin
        sw[dcsl_pkg::SW_MODE_MID] = followingValid;
      end
      default:
      begin
        sw[dcsl_pkg::SW_MODE_MID] = 1'b0;
      end
    endcase
    next_r.status = sw;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
      r.state <= dcsl_pkg::DCSL_NOT_READY;
      r.command <= dcsl_pkg::CW_RESET;
      r.limitNeg <= dcsl_pkg::LIMIT_NEG_RESET;
      r.limitPos <= dcsl_pkg::LIMIT_POS_RESET;
      r.offsetConfig <= dcsl_pkg::LOC_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign drive_command_word = r.command;
  assign drive_state_word = r.status;
  assign powerEnable = r.powerEnable;
  assign torqueEnable = r.torqueEnable;
  assign haltDecel = r.haltDecel;
  assign quickStopDecel = r.quickStopDecel;
  assign newSetpoint = r.newSetpoint;
  assign immediateTrigger = r.immediateTrigger;
  assign relativeMove = r.relativeMove;
  assign homingStart = r.homingStart;
  assign blockPositive = r.blockPositive;
  assign blockNegative = r.blockNegative;
endmodule

// ===== include/dcsl_pkg.sv
// Constants and types shared by the drive control, status and limit logic.
package dcsl_pkg;
  // Control word bit positions.
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_ENABLE_VOLTAGE = 1;
  localparam int CW_QUICK_STOP_N = 2;
  localparam int CW_ENABLE_OP = 3;
  localparam int CW_NEW_SETPOINT = 4;
  localparam int CW_IMMEDIATE = 5;
  localparam int CW_RELATIVE = 6;
  localparam int CW_FAULT_RESET = 7;
  localparam int CW_HALT = 8;
  // Status word bit positions.
  localparam int SW_READY = 0;
  localparam int SW_SWITCHED_ON = 1;
  localparam int SW_OP_ENABLED = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_VOLTAGE = 4;
  localparam int SW_QUICK_STOP = 5;
  localparam int SW_ON_DISABLED = 6;
  localparam int SW_MODE_LOW = 8;
  localparam int SW_REMOTE = 9;
  localparam int SW_TARGET = 10;
  localparam int SW_LIMIT = 11;
  localparam int SW_MODE_MID = 12;
  localparam int SW_MODE_HIGH = 13;
  // Limit offset configuration bit positions.
  localparam int LOC_RAW = 2;
  localparam int LOC_SUBTRACT = 3;
  // Low four control bits that form the commands.
  localparam logic [3:0] CMD_MASK = 4'hf;
  localparam logic [3:0] CMD_SHUTDOWN = 4'h6;
  localparam logic [3:0] CMD_SWITCH_ON = 4'h7;
  localparam logic [3:0] CMD_ENABLE = 4'hf;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [31:0] LIMIT_NEG_RESET = 32'h80000000;
  localparam logic [31:0] LIMIT_POS_RESET = 32'h7fffffff;
  localparam logic [7:0] LOC_RESET = 8'h00;

  typedef enum logic [2:0] {
    DCSL_NOT_READY = 3'b000,
    DCSL_ON_DISABLED = 3'b001,
    DCSL_READY = 3'b011,
    DCSL_SWITCHED_ON = 3'b010,
    DCSL_OP_ENABLED = 3'b110,
    DCSL_QUICK_STOP = 3'b111,
    DCSL_FAULT_REACT = 3'b101,
    DCSL_FAULT = 3'b100
  } dcsl_state_type;

  typedef enum logic [2:0] {
    DCSL_MODE_PP = 3'h1,
    DCSL_MODE_PV = 3'h3,
    DCSL_MODE_PT = 3'h4,
    DCSL_MODE_HM = 3'h6,
    DCSL_MODE_CSP = 3'h0,
    DCSL_MODE_CSV = 3'h2,
    DCSL_MODE_CST = 3'h5
  } dcsl_mode_type;
endpackage

// ===== logic/dcsl_pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module dcsl_pin_sync
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } dcsl_sync_type;

  dcsl_sync_type r;
  dcsl_sync_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.stage = {r.stage[1:0], pin};
    if (r.stage[2] == r.stage[1])
    begin
      next_r.level = r.stage[2];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign level = r.level;
endmodule

// ===== logic/dcsl_limit_calc.sv
// Effective software limits derived from raw limits and the home offset.
`timescale 1ns/1ns
module dcsl_limit_calc
(
  input wire logic [31:0] rawLimit,
  input wire logic [31:0] homeOffset,
  input wire logic [7:0] offsetConfig,
  output logic [31:0] effLimit
);
  always_comb
  begin
    if (offsetConfig[dcsl_pkg::LOC_RAW])
    begin
      effLimit = rawLimit;
    end
    else if (offsetConfig[dcsl_pkg::LOC_SUBTRACT])
    begin
      effLimit = rawLimit - homeOffset;
    end
    else
    begin
      effLimit = rawLimit + homeOffset;
    end
  end
endmodule

// ===== test/dcsl_monitor.sv
// Checker of command decoding, state coding and limit status.
`timescale 1ns/1ns
module dcsl_monitor
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdWrite,
  input wire logic [15:0] cmdData,
  input wire logic faultEvent,
  input wire logic [15:0] drive_command_word,
  input wire logic [15:0] drive_state_word,
  input wire logic blockPositive,
  input wire logic blockNegative
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  cmd_held_a:
    assert property (cmdWrite |=> drive_command_word == $past(cmdData))
    else $error("command word not held");
  remote_set_a:
    assert property ($past(rstn) |-> drive_state_word[9])
    else $error("remote bit low");
  limit_flag_a:
    assert property (drive_state_word[11] == (blockPositive | blockNegative))
    else $error("limit bit wrong");
  shutdown_ready_a:
    assert property (cmdWrite && cmdData == 16'h0006 && !faultEvent &&
      drive_state_word[6] |=> drive_state_word[6:5] == 2'b01 &&
      drive_state_word[3:0] == 4'h1)
    else $error("shutdown not taken");
  quick_stop_a:
    assert property (cmdWrite && cmdData == 16'h0002 && !faultEvent &&
      drive_state_word[6:5] == 2'b01 && drive_state_word[3:0] == 4'h7
      |=> drive_state_word[6:5] == 2'b00 && drive_state_word[3:0] == 4'h7)
    else $error("quick stop not taken");
  volt_off_a:
    assert property (cmdWrite && !cmdData[1] && !cmdData[7] && !faultEvent
      && !drive_state_word[3] |=> drive_state_word[6] &&
      drive_state_word[3:0] == 4'h0)
    else $error("voltage off not taken");
  stay_disabled_a:
    assert property (cmdWrite && drive_state_word[6] && !cmdData[7] &&
      cmdData[2:0] != 3'b110 && !faultEvent
      |=> $stable(drive_state_word[6:0]))
    else $error("invalid command moved state");
  fault_enter_a:
    assert property (faultEvent && !drive_state_word[3]
      |=> drive_state_word[3:0] == 4'hf)
    else $error("fault reaction not entered");
endmodule

bind drive_control_status_limits dcsl_monitor i_dcsl_monitor
(
  .clk(clk),
  .rstn(rstn),
  .cmdWrite(cmdWrite),
  .cmdData(cmdData),
  .faultEvent(faultEvent),
  .drive_command_word(drive_command_word),
  .drive_state_word(drive_state_word),
  .blockPositive(blockPositive),
  .blockNegative(blockNegative)
);

// ===== test/dcsl_master_model.sv
// Fieldbus master model that writes control words and limit settings.
`timescale 1ns/1ns
module dcsl_master_model
(
  input wire logic clk,
  output logic cmdWrite,
  output logic [15:0] cmdData,
  output logic limitWrite,
  output logic limitSub,
  output logic [31:0] limitData,
  output logic configWrite,
  output logic [7:0] configData
);
  initial
  begin
    {cmdWrite, limitWrite, limitSub, configWrite} = '0;
    {cmdData, limitData, configData} = '0;
  end

  // Released data is inverted so a stale value is never mistaken for live.
  task automatic send(input logic [15:0] v);
    @(negedge clk);
    cmdData = v;
    cmdWrite = 1'b1;
    @(negedge clk);
    cmdWrite = 1'b0;
    cmdData = ~v;
  endtask

  task automatic set_limit(input logic sub, input logic [31:0] v);
    @(negedge clk);
    limitSub = sub;
    limitData = v;
    limitWrite = 1'b1;
    @(negedge clk);
    limitWrite = 1'b0;
    limitData = ~v;
  endtask

  task automatic set_config(input logic [7:0] c);
    @(negedge clk);
    configData = c;
    configWrite = 1'b1;
    @(negedge clk);
    configWrite = 1'b0;
    configData = ~c;
  endtask
endmodule

// ===== test/test_drive_control_status_limits.sv
// Testbench of the drive control, status and limit block.
`timescale 1ns/1ns
module test_drive_control_status_limits;
  logic clk, rstn, preOperational, incrementalEncoder, homingDone;
  logic homingError, posErrorLarge, velocityZero, followingValid;
  logic abnormalStop, targetReached, faultEvent, faultReactionDone;
  logic hwLimitPosPin, hwLimitNegPin, cmdWrite, limitWrite, limitSub;
  logic configWrite, powerEnable, torqueEnable, haltDecel;
  logic quickStopDecel, newSetpoint, immediateTrigger, relativeMove;
  logic homingStart, blockPositive, blockNegative;
  logic [2:0] opMode;
  logic [7:0] configData;
  logic [15:0] cmdData, drive_command_word, drive_state_word;
  logic [31:0] limitData, homeOffset, targetPosition, actualPosition;
  logic [15:0] steps [4] = '{16'h0000, 16'h0006, 16'h0007, 16'h000f};
  logic [15:0] masks [4] = '{16'h0250, 16'h0231, 16'h0233, 16'h0237};
  logic [7:0] cfgs [3] = '{8'h00, 8'h08, 8'h04};
  logic [31:0] effs [3] = '{32'h6e, 32'h5a, 32'h64};
  logic [2:0] modes [7] = '{3'h1, 3'h3, 3'h4, 3'h6, 3'h0, 3'h2, 3'h5};
  logic [2:0] flags [7] = '{3'h5, 3'h2, 3'h0, 3'h7, 3'h3, 3'h2, 3'h2};
  int n_errors = 0, n_compared = 0, cycles = 0;

  dcsl_master_model i_dcsl_master_model
  (
    .clk(clk), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .limitWrite(limitWrite), .limitSub(limitSub), .limitData(limitData),
    .configWrite(configWrite), .configData(configData)
  );

  drive_control_status_limits i_drive_control_status_limits
  (
    .clk(clk), .rstn(rstn), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .opMode(opMode), .preOperational(preOperational),
    .limitWrite(limitWrite), .limitSub(limitSub), .limitData(limitData),
    .configWrite(configWrite), .configData(configData),
    .homeOffset(homeOffset), .targetPosition(targetPosition),
    .actualPosition(actualPosition),
    .incrementalEncoder(incrementalEncoder), .homingDone(homingDone),
    .homingError(homingError), .posErrorLarge(posErrorLarge),
    .velocityZero(velocityZero), .followingValid(followingValid),
    .abnormalStop(abnormalStop), .targetReached(targetReached),
    .faultEvent(faultEvent), .faultReactionDone(faultReactionDone),
    .hwLimitPosPin(hwLimitPosPin), .hwLimitNegPin(hwLimitNegPin),
    .drive_command_word(drive_command_word),
    .drive_state_word(drive_state_word), .powerEnable(powerEnable),
    .torqueEnable(torqueEnable), .haltDecel(haltDecel),
    .quickStopDecel(quickStopDecel), .newSetpoint(newSetpoint),
    .immediateTrigger(immediateTrigger), .relativeMove(relativeMove),
    .homingStart(homingStart), .blockPositive(blockPositive),
    .blockNegative(blockNegative)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string w, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic sw(input string w, input logic [15:0] m, e);
    chk(w, e, drive_state_word & m);
  endtask

  task automatic lim(input string w, input logic [15:0] e);
    chk(w, e, {4'h0, drive_state_word[11], 9'h0, blockNegative,
      blockPositive});
  endtask

  task automatic cw(input logic [15:0] v);
    i_dcsl_master_model.send(v);
  endtask

  task automatic wait2();
    repeat (2) @(negedge clk);
  endtask

  task automatic enable_drive();
    for (int i = 0; i < 4; i++)
    begin
      cw(steps[i]);
      sw("enable step", masks[i], masks[i]);
    end
  endtask

  initial
  begin
    {preOperational, incrementalEncoder, homingDone, homingError} = '0;
    {posErrorLarge, velocityZero, followingValid, abnormalStop} = '0;
    {targetReached, faultEvent, faultReactionDone} = '0;
    {hwLimitPosPin, hwLimitNegPin, rstn, opMode} = '0;
    // No offset until the limit tests, so the reset limits cannot wrap.
    homeOffset = 32'h00000000;
    {targetPosition, actualPosition} = '0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    wait2();
    sw("after reset", 16'hffff, 16'h0250);
    enable_drive();
    cw(16'h0002);
    sw("quick stop", 16'h006f, 16'h0007);
    chk("qs outputs", 16'h0007, {13'h0, powerEnable, torqueEnable,
      quickStopDecel});
    cw(16'h000f);
    sw("quick stop return", 16'h006f, 16'h0027);
    cw(16'h0006);
    sw("shutdown", 16'h006f, 16'h0021);
    cw(16'h000f);
    sw("enable from ready", 16'h006f, 16'h0023);
    cw(16'h000f);
    opMode = 3'h1;
    cw(16'h017f);
    chk("pp controls", 16'h000f, {12'h0, haltDecel, relativeMove,
      immediateTrigger, newSetpoint});
    opMode = 3'h6;
    cw(16'h001f);
    chk("homing start", 16'h0001, {15'h0, homingStart});
    {posErrorLarge, velocityZero, followingValid, abnormalStop} = '1;
    {homingDone, homingError} = '1;
    for (int i = 0; i < 7; i++)
    begin
      opMode = modes[i];
      wait2();
      chk("mode flags", {13'h0, flags[i]}, {13'h0,
        drive_state_word[13:12], drive_state_word[8]});
    end
    {posErrorLarge, velocityZero, followingValid, abnormalStop} = '0;
    {homingDone, homingError} = '0;
    cw(16'h0000);
    sw("voltage off", 16'h004f, 16'h0040);
    chk("off outputs", 16'h0000, {13'h0, powerEnable, torqueEnable,
      quickStopDecel});
    cw(16'h0007);
    sw("invalid kept", 16'h004f, 16'h0040);
    faultEvent = 1'b1;
    @(negedge clk);
    faultEvent = 1'b0;
    sw("fault reaction", 16'h004f, 16'h000f);
    faultReactionDone = 1'b1;
    @(negedge clk);
    faultReactionDone = 1'b0;
    sw("fault", 16'h004f, 16'h0008);
    cw(16'h0080);
    @(negedge clk);
    sw("fault reset", 16'h004f, 16'h0040);
    chk("command word", 16'h0080, drive_command_word);
    enable_drive();
    opMode = 3'h0;
    homeOffset = 32'h0000000a;
    preOperational = 1'b1;
    i_dcsl_master_model.set_limit(1'b0, 32'hffffff9c);
    i_dcsl_master_model.set_limit(1'b1, 32'h00000064);
    for (int i = 0; i < 3; i++)
    begin
      i_dcsl_master_model.set_config(cfgs[i]);
      targetPosition = effs[i];
      wait2();
      lim("at limit", 16'h0000);
      targetPosition = effs[i] + 32'h1;
      wait2();
      lim("past limit", 16'h0801);
    end
    targetPosition = 32'hffffff9b;
    wait2();
    lim("negative limit", 16'h0802);
    preOperational = 1'b0;
    i_dcsl_master_model.set_config(8'h00);
    targetPosition = 32'h00000065;
    wait2();
    lim("config locked", 16'h0801);
    // Relative moves exist only in profile position mode.
    opMode = 3'h1;
    cw(16'h004f);
    wait2();
    lim("relative move", 16'h0000);
    cw(16'h000f);
    incrementalEncoder = 1'b1;
    wait2();
    lim("not homed", 16'h0000);
    homingDone = 1'b1;
    wait2();
    lim("homed", 16'h0801);
    opMode = 3'h3;
    wait2();
    lim("velocity mode", 16'h0000);
    hwLimitPosPin = 1'b1;
    repeat (8) @(negedge clk);
    lim("hardware limit", 16'h0801);
    report_and_stop();
  end
endmodule
